// ---- design/oc_pkg.sv ----
package oc_pkg;
    localparam logic [15:0] COUNTER_RESET  = 16'hFFFC;
    localparam logic [15:0] CAPTURE_OPM    = 16'hFFFD;
    localparam logic [15:0] COMPARE_RESET  = 16'h8000;
    localparam int          PULSE_OFFSET   = 5;
    // byte register indices (8-bit data, low bits of the bus)
    localparam logic [3:0] ADDR_CTRL1     = 4'h0;
    localparam logic [3:0] ADDR_CTRL2     = 4'h1;
    localparam logic [3:0] ADDR_STATUS    = 4'h2;
    localparam logic [3:0] ADDR_CAP1_HI   = 4'h3;
    localparam logic [3:0] ADDR_CAP1_LO   = 4'h4;
    localparam logic [3:0] ADDR_CMP1_HI   = 4'h5;
    localparam logic [3:0] ADDR_CMP1_LO   = 4'h6;
    localparam logic [3:0] ADDR_CNT_HI    = 4'h7;
    localparam logic [3:0] ADDR_CNT_LO    = 4'h8;
    localparam logic [3:0] ADDR_CAP2_HI   = 4'h9;
    localparam logic [3:0] ADDR_CAP2_LO   = 4'hA;
    localparam logic [3:0] ADDR_CMP2_HI   = 4'hB;
    localparam logic [3:0] ADDR_CMP2_LO   = 4'hC;
    // control one fields
    localparam int C1_CAPIE  = 7;
    localparam int C1_CMPIE  = 6;
    localparam int C1_EDGE1  = 1;
    localparam int C1_LVL1   = 0;
    localparam int C1_FORCE2 = 4;
    localparam int C1_FORCE1 = 3;
    localparam int C1_LVL2   = 2;
    // control two fields
    localparam int C2_PIN1   = 7;
    localparam int C2_PIN2   = 6;
    localparam int C2_OPM    = 5;
    localparam int C2_PWM    = 4;
    localparam int C2_CLKHI  = 3;
    localparam int C2_CLKLO  = 2;
    localparam int C2_EDGE2  = 1;
    localparam int C2_EXTEDG = 0;
    // status fields
    localparam int ST_CAP1 = 7;
    localparam int ST_CMP1 = 6;
    localparam int ST_CAP2 = 4;
    localparam int ST_CMP2 = 3;
    localparam logic [1:0] CLK_DIV2 = 2'b00;
    localparam logic [1:0] CLK_DIV4 = 2'b01;
    localparam logic [1:0] CLK_DIV8 = 2'b10;
    localparam logic [1:0] CLK_EXT  = 2'b11;
endpackage : oc_pkg

// ---- design/output_compare_one_pulse.sv ----
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/100ps
// How it works
// - two 16-bit compare values checked against the counter every timer tick
// - compare values software read/write only, reset to 8000h
// - match sets flag i and drives level i on enabled pin i
// - compare interrupt needs compare irq enable and cleared cpu mask
// - flag cleared by status read while set, then low byte access
// - high byte write inhibits compare until low byte written
// - disabled pin gets no level, interrupt still possible
// - flag and pin set in the tick where counter equals compare
// - force copies level to enabled pin, no flag, no interrupt
// - force ignored in one-pulse or pwm mode
// - tick is cpu clock over 2, 4, 8 or external clock
// - one-pulse mode uses capture 1 with compare 1
// - trigger edge: counter FFFCh, level 2 on pin 1, flag, capture FFFDh
// - trigger capture flag raises interrupt if capture irq enabled
// - counter equal compare 1 drives level 1, ending pulse
// - pulse length is compare value 1 plus 5 ticks
// - one-pulse: flag 1 never set, compare 2 still works
// - both mode bits set means only pwm mode
// - equal levels give constant output
// - capture input 1 does no capture in one-pulse mode
// - compare 2 drives no pin in one-pulse mode
// - counter free-runs, resets to FFFCh, reload on low byte write
module output_compare_one_pulse (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wrData,
    input  wire logic       wrStb,
    input  wire logic       rdStb,
    output logic      [7:0] rdData,
    input  wire logic       cpuIrqMask,
    input  wire logic       capturePin1,
    input  wire logic       capturePin2,
    input  wire logic       extClockPin,
    output logic            comparePin1,
    output logic            comparePin1Oe,
    output logic            comparePin2,
    output logic            comparePin2Oe,
    output logic            timerIrq
);
    import oc_pkg::*;

    logic [7:0]  ctrl1;
    logic [7:0]  ctrl2;
    logic [15:0] counter;
    logic [15:0] cmpVal [2];
    logic [15:0] capVal [2];
    logic [1:0]  cmpFlag;
    logic [1:0]  capFlag;
    logic [1:0]  cmpInhibit;
    logic [1:0]  cmpArm;
    logic [1:0]  capArm;
    logic [1:0]  capInhibit;
    logic [7:0]  cntLatch;
    logic        cntLatched;
    logic [2:0]  ca1Sync;
    logic [2:0]  ca2Sync;
    logic [2:0]  extSync;
    logic [2:0]  divCnt;
    logic        tick;
    logic        pwmMode;
    logic        opmMode;
    logic [1:0]  match;
    logic        cap1Edge;
    logic        cap2Edge;
    logic        extEdge;
    logic [7:0]  statusByte;

    assign pwmMode = ctrl2[C2_PWM];
    assign opmMode = ctrl2[C2_OPM] & ~ctrl2[C2_PWM];

    // synchronisers: stage 0 only feeds stage 1
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ca1Sync <= 3'h0;
            ca2Sync <= 3'h0;
            extSync <= 3'h0;
        end else begin
            ca1Sync <= {ca1Sync[1:0], capturePin1};
            ca2Sync <= {ca2Sync[1:0], capturePin2};
            extSync <= {extSync[1:0], extClockPin};
        end
    end

    assign cap1Edge = ctrl1[C1_EDGE1] ? (ca1Sync[1] & ~ca1Sync[2]) : (~ca1Sync[1] & ca1Sync[2]);
    assign cap2Edge = ctrl2[C2_EDGE2] ? (ca2Sync[1] & ~ca2Sync[2]) : (~ca2Sync[1] & ca2Sync[2]);
    assign extEdge  = ctrl2[C2_EXTEDG] ? (extSync[1] & ~extSync[2]) : (~extSync[1] & extSync[2]);

    // tick divider; external edge used directly as tick enable
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            divCnt <= 3'h0;
        end else begin
            divCnt <= divCnt + 3'h1;
        end
    end

    always_comb begin
        case (ctrl2[C2_CLKHI:C2_CLKLO])
            CLK_DIV2: tick = divCnt[0];
            CLK_DIV4: tick = &divCnt[1:0];
            CLK_DIV8: tick = &divCnt;
            CLK_EXT:  tick = extEdge;
            default:  tick = 1'b0;
        endcase
    end

    logic wrCntLo;
    logic opmTrig;
    assign wrCntLo = wrStb && addr == ADDR_CNT_LO;
    assign opmTrig = opmMode && cap1Edge;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            counter <= COUNTER_RESET;
        end else if (wrCntLo || opmTrig) begin
            counter <= COUNTER_RESET;
        end else if (tick) begin
            counter <= counter + 16'h0001;
        end
    end

    // match is sampled on the tick that leaves the matching value, once per value
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            match[i] = tick && !cmpInhibit[i] && counter == cmpVal[i];
        end
    end

    logic [1:0] wrCmpHi;
    logic [1:0] accCmpLo;
    logic [1:0] accCapLo;
    logic [1:0] rdCapHi;
    logic       rdStatus;
    assign wrCmpHi[0]  = wrStb && addr == ADDR_CMP1_HI;
    assign wrCmpHi[1]  = wrStb && addr == ADDR_CMP2_HI;
    assign accCmpLo[0] = (wrStb || rdStb) && addr == ADDR_CMP1_LO;
    assign accCmpLo[1] = (wrStb || rdStb) && addr == ADDR_CMP2_LO;
    assign accCapLo[0] = (wrStb || rdStb) && addr == ADDR_CAP1_LO;
    assign accCapLo[1] = (wrStb || rdStb) && addr == ADDR_CAP2_LO;
    assign rdCapHi[0]  = rdStb && addr == ADDR_CAP1_HI;
    assign rdCapHi[1]  = rdStb && addr == ADDR_CAP2_HI;
    assign rdStatus    = rdStb && addr == ADDR_STATUS;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl1 <= 8'h00;
            ctrl2 <= 8'h00;
        end else if (wrStb && addr == ADDR_CTRL1) begin
            ctrl1 <= wrData;
        end else if (wrStb && addr == ADDR_CTRL2) begin
            ctrl2 <= wrData;
        end
    end

    // compare values: only software writes them
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cmpVal[0]  <= COMPARE_RESET;
            cmpVal[1]  <= COMPARE_RESET;
            cmpInhibit <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (wrCmpHi[i]) begin
                    cmpVal[i][15:8] <= wrData;
                    cmpInhibit[i]   <= 1'b1;
                end else if (wrStb && accCmpLo[i]) begin
                    cmpVal[i][7:0] <= wrData;
                    cmpInhibit[i]  <= 1'b0;
                end
            end
        end
    end

    // flags: set beats clear in the same cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cmpFlag <= 2'b00;
            cmpArm  <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (rdStatus && cmpFlag[i]) begin
                    cmpArm[i] <= 1'b1;
                end else if (accCmpLo[i]) begin
                    cmpArm[i] <= 1'b0;
                end
            end
            // compare 1 never flags in one-pulse, neither flags in pwm
            if (match[0] && !opmMode && !pwmMode) begin
                cmpFlag[0] <= 1'b1;
            end else if (accCmpLo[0] && cmpArm[0]) begin
                cmpFlag[0] <= 1'b0;
            end
            if (match[1] && !pwmMode) begin
                cmpFlag[1] <= 1'b1;
            end else if (accCmpLo[1] && cmpArm[1]) begin
                cmpFlag[1] <= 1'b0;
            end
        end
    end

    // capture: pin 1 captures nothing in one-pulse, trigger loads fixed value
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            capFlag    <= 2'b00;
            capArm     <= 2'b00;
            capInhibit <= 2'b00;
            capVal[0]  <= 16'h0000;
            capVal[1]  <= 16'h0000;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (rdStatus && capFlag[i]) begin
                    capArm[i] <= 1'b1;
                end else if (accCapLo[i]) begin
                    capArm[i] <= 1'b0;
                end
                if (rdCapHi[i]) begin
                    capInhibit[i] <= 1'b1;
                end else if (accCapLo[i]) begin
                    capInhibit[i] <= 1'b0;
                end
            end
            if (opmTrig) begin
                capFlag[0] <= 1'b1;
                capVal[0]  <= CAPTURE_OPM;
            end else if (cap1Edge && !opmMode && !pwmMode && !capInhibit[0]) begin
                capFlag[0] <= 1'b1;
                capVal[0]  <= counter;
            end else if (accCapLo[0] && capArm[0]) begin
                capFlag[0] <= 1'b0;
            end
            if (cap2Edge && !capInhibit[1]) begin
                capFlag[1] <= 1'b1;
                capVal[1]  <= counter;
            end else if (accCapLo[1] && capArm[1]) begin
                capFlag[1] <= 1'b0;
            end
        end
    end

    // pin 1: trigger starts pulse with level 2, compare 1 ends it with level 1
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            comparePin1 <= 1'b0;
        end else if (opmMode) begin
            if (opmTrig) begin
                comparePin1 <= ctrl1[C1_LVL2];
            end else if (match[0]) begin
                comparePin1 <= ctrl1[C1_LVL1];
            end
        end else if (!pwmMode && (match[0] || ctrl1[C1_FORCE1])) begin
            comparePin1 <= ctrl1[C1_LVL1];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            comparePin2 <= 1'b0;
        end else if (!opmMode && !pwmMode && (match[1] || ctrl1[C1_FORCE2])) begin
            comparePin2 <= ctrl1[C1_LVL2];
        end
    end

    // pin stays general io while its enable is clear
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            comparePin1Oe <= 1'b0;
            comparePin2Oe <= 1'b0;
        end else begin
            comparePin1Oe <= ctrl2[C2_PIN1];
            comparePin2Oe <= ctrl2[C2_PIN2] & ~opmMode & ~pwmMode;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            timerIrq <= 1'b0;
        end else begin
            timerIrq <= !cpuIrqMask && ((ctrl1[C1_CMPIE] && |cmpFlag)
                        || (ctrl1[C1_CAPIE] && |capFlag));
        end
    end

    assign statusByte = {capFlag[0], cmpFlag[0], 1'b0, capFlag[1], cmpFlag[1], 3'h0};

    // counter low byte is held after a high byte read
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cntLatch   <= 8'h00;
            cntLatched <= 1'b0;
        end else if (rdStb && addr == ADDR_CNT_HI && !cntLatched) begin
            cntLatch   <= counter[7:0];
            cntLatched <= 1'b1;
        end else if (rdStb && addr == ADDR_CNT_LO) begin
            cntLatched <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdData <= 8'h00;
        end else if (rdStb) begin
            case (addr)
                ADDR_CTRL1:   rdData <= ctrl1;
                ADDR_CTRL2:   rdData <= ctrl2;
                ADDR_STATUS:  rdData <= statusByte;
                ADDR_CAP1_HI: rdData <= capVal[0][15:8];
                ADDR_CAP1_LO: rdData <= capVal[0][7:0];
                ADDR_CMP1_HI: rdData <= cmpVal[0][15:8];
                ADDR_CMP1_LO: rdData <= cmpVal[0][7:0];
                ADDR_CNT_HI:  rdData <= counter[15:8];
                ADDR_CNT_LO:  rdData <= cntLatched ? cntLatch : counter[7:0];
                ADDR_CAP2_HI: rdData <= capVal[1][15:8];
                ADDR_CAP2_LO: rdData <= capVal[1][7:0];
                ADDR_CMP2_HI: rdData <= cmpVal[1][15:8];
                ADDR_CMP2_LO: rdData <= cmpVal[1][7:0];
                default:      rdData <= 8'h00;
            endcase
        end else begin
            rdData <= 8'h00;
        end
    end

    AST_FLAG_ON_MATCH: assert property (@(posedge mclk) disable iff (rst)
        match[1] && !pwmMode |=> cmpFlag[1]) else $error("compare 2 flag not set");
    AST_NO_FLAG1_OPM: assert property (@(posedge mclk) disable iff (rst)
        opmMode && !cmpFlag[0] && $past(!cmpFlag[0]) |=> !$rose(cmpFlag[0]) || !$past(opmMode))
        else $error("flag 1 set in one-pulse");
    AST_TRIG_COUNTER: assert property (@(posedge mclk) disable iff (rst)
        opmTrig |=> counter == COUNTER_RESET && capVal[0] == CAPTURE_OPM && capFlag[0])
        else $error("trigger reload wrong");
    AST_TRIG_PIN: assert property (@(posedge mclk) disable iff (rst)
        opmTrig |=> comparePin1 == $past(ctrl1[C1_LVL2])) else $error("pulse not started");
    AST_INHIBIT: assert property (@(posedge mclk) disable iff (rst)
        wrCmpHi[1] |=> !match[1]) else $error("compare not inhibited");
    AST_CNT_RELOAD: assert property (@(posedge mclk) disable iff (rst)
        wrCntLo |=> counter == COUNTER_RESET) else $error("counter not reloaded");
    AST_IRQ_MASK: assert property (@(posedge mclk) disable iff (rst)
        cpuIrqMask |=> !timerIrq) else $error("irq despite mask");
    AST_CLEAR_SEQ: assert property (@(posedge mclk) disable iff (rst)
        $fell(cmpFlag[1]) |-> $past(accCmpLo[1]) && $past(cmpArm[1]))
        else $error("flag cleared without sequence");
    COV_OPM_PULSE: cover property (@(posedge mclk) opmTrig ##[1:300] match[0]);
    COV_FORCE: cover property (@(posedge mclk) ctrl1[C1_FORCE1] && !opmMode);
    COV_IRQ: cover property (@(posedge mclk) $rose(timerIrq));
endmodule : output_compare_one_pulse

// ---- sim/pin_partner.sv ----
`timescale 1ns/100ps
module pin_partner (
    input  wire logic mclk,
    input  wire logic comparePin1,
    input  wire logic comparePin1Oe,
    input  wire logic comparePin2,
    input  wire logic comparePin2Oe,
    output logic      capturePin1,
    output logic      capturePin2,
    output logic      extClockPin,
    output wire logic pad1,
    output wire logic pad2
);
    logic       extRun;
    logic [1:0] extDiv;
    // pull-ups: a pin left as general io reads high
    assign pad1 = comparePin1Oe ? comparePin1 : 1'b1;
    assign pad2 = comparePin2Oe ? comparePin2 : 1'b1;
    initial begin
        capturePin1 = 1'b0;
        capturePin2 = 1'b0;
        extClockPin = 1'b0;
        extRun      = 1'b0;
        extDiv      = 2'h0;
    end
    // mclk/8, below a quarter of the cpu clock; stands still when unused
    always @(posedge mclk) begin
        if (extRun) begin
            extDiv <= extDiv + 2'h1;
            if (extDiv == 2'h3) begin
                extClockPin <= ~extClockPin;
            end
        end
    end
    // held several cycles so the synchroniser sees it
    task automatic pulse(input bit two, input int hold);
        @(posedge mclk);
        if (two) capturePin2 <= 1'b1;
        else capturePin1 <= 1'b1;
        repeat (hold) @(posedge mclk);
        capturePin1 <= 1'b0;
        capturePin2 <= 1'b0;
    endtask : pulse
endmodule : pin_partner

// ---- sim/output_compare_one_pulse_tb.sv ----
`timescale 1ns/100ps
module output_compare_one_pulse_tb;
    import oc_pkg::*;
    logic            mclk, rst, wrStb, rdStb, cpuIrqMask;
    logic      [3:0] addr;
    logic      [7:0] wrData, rd;
    wire logic [7:0] rdData;
    wire logic       cap1, cap2, extClk, pin1, pin1Oe, pin2, pin2Oe, timerIrq, pad1, pad2;
    int              fails, comparisons, cyc, took, dv;
    output_compare_one_pulse uut (
        .mclk(mclk), .rst(rst), .addr(addr), .wrData(wrData), .wrStb(wrStb),
        .rdStb(rdStb), .rdData(rdData), .cpuIrqMask(cpuIrqMask), .capturePin1(cap1),
        .capturePin2(cap2), .extClockPin(extClk), .comparePin1(pin1),
        .comparePin1Oe(pin1Oe), .comparePin2(pin2), .comparePin2Oe(pin2Oe),
        .timerIrq(timerIrq)
    );
    pin_partner partner (
        .mclk(mclk), .comparePin1(pin1), .comparePin1Oe(pin1Oe), .comparePin2(pin2),
        .comparePin2Oe(pin2Oe), .capturePin1(cap1), .capturePin2(cap2),
        .extClockPin(extClk), .pad1(pad1), .pad2(pad2)
    );
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    initial cyc = 0;
    always @(posedge mclk) cyc <= cyc + 1;
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr   <= a;
        wrData <= d;
        wrStb  <= 1'b1;
        @(posedge mclk);
        wrStb  <= 1'b0;
    endtask : wr
    // read data only valid in the cycle after the strobe
    task automatic rdb(input logic [3:0] a);
        @(posedge mclk);
        addr  <= a;
        rdStb <= 1'b1;
        @(posedge mclk);
        rdStb <= 1'b0;
        #1;
        rd = rdData;
    endtask : rdb
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    task automatic chkr(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        rdb(a);
        chk(16'(rd & m), 16'(e), "register read");
    endtask : chkr
    task automatic wr16(input logic [3:0] hi, input logic [15:0] v);
        wr(hi, v[15:8]);
        wr(hi + 4'h1, v[7:0]);
    endtask : wr16
    // counts cycles until the pin shows lvl, gives up at maxc
    task automatic waitPin(input bit two, input logic lvl, input int maxc);
        took = 0;
        while (took < maxc && (two ? pin2 : pin1) !== lvl) begin
            @(posedge mclk);
            #1;
            took++;
        end
    endtask : waitPin
    initial begin
        #300000;
        fails++;
        $display("[ERR] %0t watchdog expired", $time);
        stop_test();
    end
    initial begin
        rst = 1'b1;
        wrStb = 1'b0;
        rdStb = 1'b0;
        addr = 4'h0;
        wrData = 8'h00;
        cpuIrqMask = 1'b0;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        #1;
        chk(16'({pin1, pin2, timerIrq}), 16'h0000, "pins low"); // latch low
        chkr(ADDR_CMP1_HI, 8'hFF, 8'h80); // reset value
        chkr(ADDR_CMP1_LO, 8'hFF, 8'h00); // reset value
        chkr(ADDR_CMP2_HI, 8'hFF, 8'h80); // reset value
        chkr(ADDR_CMP2_LO, 8'hFF, 8'h00); // reset value
        wr(4'hD, 8'hFF);
        chkr(4'hD, 8'hFF, 8'h00);
        wr16(ADDR_CMP2_HI, 16'hF0A5); // far away, never reached
        chkr(ADDR_CMP2_HI, 8'hFF, 8'hF0); // read back
        chkr(ADDR_CMP2_LO, 8'hFF, 8'hA5); // read back
        $display("test reset done");
        for (int k = 0; k < 4; k++) begin
            dv = (k == 0) ? 2 : (k == 1) ? 4 : 8;
            partner.extRun = (k == 3);
            wr(ADDR_CTRL2, {4'b1000, 2'(k), 2'b00});
            // restart so the counter sits well below the new compare value
            wr(ADDR_CNT_LO, 8'h00);
            wr(ADDR_CTRL1, 8'h08);
            repeat (2) @(posedge mclk);
            #1;
            chk(16'({pin1Oe, pin1}), 16'h0002, "forced low"); // copy level
            wr(ADDR_CMP1_HI, 8'h00); // hi, status, lo order
            rdb(ADDR_STATUS);
            wr(ADDR_CMP1_LO, 8'h10);
            chkr(ADDR_STATUS, 8'hFF, 8'h00); // no flag from force
            wr(ADDR_CTRL1, 8'h41);
            wr(ADDR_CNT_LO, 8'h00); // reload to FFFCh
            waitPin(0, 1'b1, 400);
            chk(16'(took >= 20 * dv - 2 && took <= 21 * dv + 6), 16'h1, "tick");
            repeat (2) @(posedge mclk);
            chk(16'(timerIrq), 16'h1, "irq"); // enabled and unmasked
            cpuIrqMask <= 1'b1;
            repeat (3) @(posedge mclk);
            chk(16'(timerIrq), 16'h0, "masked"); // cpu mask
            cpuIrqMask <= 1'b0;
            rdb(ADDR_CMP1_LO);
            chkr(ADDR_STATUS, 8'h40, 8'h40); // no status read while set before
            rdb(ADDR_CMP1_LO);
            chkr(ADDR_STATUS, 8'h40, 8'h00); // cleared by the pair
        end
        partner.extRun = 1'b0;
        $display("test compare done");
        wr(ADDR_CTRL2, 8'h80);
        // pin 1 forced low; compare 1 held off so the irq is compare 2 alone
        wr(ADDR_CTRL1, 8'h48);
        wr(ADDR_CMP1_HI, 8'h00);
        wr(ADDR_CMP2_HI, 8'h00);
        wr(ADDR_CNT_LO, 8'h00);
        repeat (400) @(posedge mclk); // passes 00A5h while inhibited
        chkr(ADDR_STATUS, 8'h08, 8'h00); // hi write inhibits
        wr(ADDR_CMP2_LO, 8'h10);
        wr(ADDR_CNT_LO, 8'h00);
        repeat (60) @(posedge mclk);
        chk(16'({timerIrq, pin2Oe, pad2}), 16'h0005, "io pin"); // no level
        chkr(ADDR_STATUS, 8'h08, 8'h08); // lo write enables
        wr16(ADDR_CMP2_HI, 16'h0003);
        $display("test inhibit done");
        wr(ADDR_CTRL2, 8'hE2);
        wr(ADDR_CTRL1, 8'h09);
        repeat (4) @(posedge mclk);
        chk(16'(pin1), 16'h0, "force in one-pulse"); // ignored
        wr(ADDR_CTRL1, 8'h86);
        wr16(ADDR_CMP1_HI, 16'h000A); // 10 + 5 ticks
        partner.pulse(0, 8);
        waitPin(0, 1'b1, 20);
        chk(16'(took < 20), 16'h1, "pulse start"); // level 2 on trigger
        waitPin(0, 1'b0, 80);
        // waiting began 5 edges after the trigger edge; 15 ticks of 2 cycles
        chk(16'(took + 5 >= 29 && took + 5 <= 31), 16'h1, "pulse length");
        partner.pulse(1, 8);
        repeat (4) @(posedge mclk);
        chk(16'({timerIrq, pin2}), 16'h0002, "flag irq"); // capture irq, no wave
        chkr(ADDR_STATUS, 8'hD8, 8'h98);
        chkr(ADDR_CAP1_HI, 8'hFF, 8'hFF); // loaded value
        chkr(ADDR_CAP1_LO, 8'hFF, 8'hFD); // loaded value
        chkr(ADDR_STATUS, 8'h80, 8'h00); // status then low byte
        wr(ADDR_CTRL1, 8'h82);
        partner.pulse(0, 8);
        waitPin(0, 1'b1, 60);
        chk(16'(took), 16'd60, "equal levels"); // steady output
        wr(ADDR_CTRL2, 8'hB2);
        wr(ADDR_CTRL1, 8'h86);
        partner.pulse(0, 8);
        waitPin(0, 1'b1, 40);
        chk(16'(took), 16'd40, "pwm wins"); // no pulse
        $display("test one-pulse done");
        stop_test();
    end
endmodule : output_compare_one_pulse_tb
